// [pkg/ipfe_pkg.sv]
// Constants, types and mode codes shared by both ends of the interrupt pin front end.
// Assumes one 50 MHz clock (clk) and an asynchronous active-low reset (arst_n) on both ends.
package ipfe_pkg;

	// Number of interrupt pins on the device.
	localparam int unsigned IPFE_NUM_IRQ = 4;

	// Cycles the pin must be seen inactive, then active, before a request counts.
	localparam int unsigned IPFE_MIN_INACTIVE = 2;
	localparam int unsigned IPFE_MIN_ACTIVE   = 2;

	// Least reset length, in double-rate clock cycles, as printed.
	localparam int unsigned IPFE_RESET_MIN_DOUBLE_RATE_CLOCK = 41;

	// Reset value of the acknowledge output latch (pin idles high).
	localparam logic IPFE_ACK_RESET = 1'b1;

	// Interrupt pin index of each line.
	localparam int unsigned IPFE_IRQ_ZERO  = 0;
	localparam int unsigned IPFE_IRQ_ONE   = 1;
	localparam int unsigned IPFE_IRQ_TWO   = 2;
	localparam int unsigned IPFE_IRQ_THREE = 3;

	// Initialization choice taken from the reset-time strap sample.
	typedef enum logic [1:0] {
		IPFE_INIT_SELF_TEST,
		IPFE_INIT_SKIP_TEST,
		IPFE_INIT_EMULATION,
		IPFE_INIT_RESERVED
	} ipfe_init_e;

endpackage : ipfe_pkg

// [pkg/ipfe_if.sv]
// Pin-level carrier between the device front end and the external interrupt source.
// Assumes the testbench resolves the fourth pin's level from the two enables.
`timescale 1ns/1ns
interface ipfe_if;
	// Active-low interrupt lines zero to two, driven by the source.
	logic [2:0] irq_n_low;
	// Fourth pin: source drive and enable, device drive and enable, resolved level.
	logic       irq_three_src_o;
	logic       irq_three_src_oe;
	logic       irq_three_or_ack_out_o;
	logic       irq_three_or_ack_out_oe;
	logic       irq_three_i;
	// Active-low bus lock pin, sampled by the device during reset.
	logic       lock_n;

	// Device end.
	modport device (
		input  irq_n_low, irq_three_i, lock_n,
		output irq_three_or_ack_out_o, irq_three_or_ack_out_oe
	);
	// External source or controller end.
	modport source (
		input  irq_three_i, irq_three_or_ack_out_oe,
		output irq_n_low, irq_three_src_o, irq_three_src_oe, lock_n
	);
endinterface : ipfe_if

// [hdl/ipfe_device.sv]
// Device end: synchronizes interrupt pins, detects requests, runs dual-use pins
// and latches the reset-time strap choice. Assumes pins are asynchronous to clk.
`timescale 1ns/1ns
module ipfe_device
	import ipfe_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Pins toward the outside party.
	ipfe_if.device           pins,
	// Interrupt control settings from the core.
	input  wire logic        vector_valid,
	input  wire logic        ext_mode,
	input  wire logic        ack_mode,
	input  wire logic        ack_drive,
	input  wire logic        ack_active,
	// Results toward the core.
	output logic [3:0]       irq_pulse,
	output logic             ext_controller_request,
	output ipfe_init_e       init_mode,
	output logic             on_circuit_emulation_mode
);

	// Raw active-high view of the four interrupt pins and the lock pin.
	logic [4:0] raw_in;
	assign raw_in = {~pins.lock_n, ~pins.irq_three_i, ~pins.irq_n_low};

	// Two-flop synchronizer; stage one feeds only stage two.
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	// A reset synchronizer gives a clean "in reset" flag seen as a clocked level.
	// Strap sampling then stays legal: the flops load pins only on clock edges.
	logic rst_sync1_r;
	logic rst_sync2_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end

	// Strap capture: keep sampling until reset is fully released, then freeze.
	// Only the first edge after release still samples reset-time pin levels; the third edge loads them and freezes.
	logic [3:0] strap_r; // {lock_low, three_low, one_low, zero_low}
	logic       strap_frozen_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_r        <= 4'h0;
			strap_frozen_r <= 1'b0;
		end else if (!strap_frozen_r) begin
			strap_r <= {sync2_r[4], sync2_r[3], sync2_r[1], sync2_r[0]};
			if (rst_sync2_r)
				strap_frozen_r <= 1'b1;
		end
	end

	// Decode the strap: lock low wins over everything, then the reserved codes.
	always_comb begin
		if (strap_r[3])
			init_mode = IPFE_INIT_EMULATION;
		else if (strap_r[2])
			init_mode = IPFE_INIT_RESERVED;
		else if (!strap_r[0])
			init_mode = IPFE_INIT_SELF_TEST;
		else if (strap_r[1])
			init_mode = IPFE_INIT_SKIP_TEST;
		else
			init_mode = IPFE_INIT_RESERVED;
	end
	assign on_circuit_emulation_mode = strap_r[3];

	// Each line needs a number of inactive cycles, then active cycles, before a pulse.
	// Counting in clk cycles covers both the synchronous and asynchronous cases.
	logic [3:0] line_en;
	assign line_en = {~ack_mode, ~ext_mode, 2'b11};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_line
			logic [1:0] idle_cnt_r; // Saturating count of inactive cycles.
			logic [1:0] act_cnt_r;  // Count of active cycles after arming.
			logic       armed_r;
			logic       pulse_r;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					idle_cnt_r <= 2'h0;
					act_cnt_r  <= 2'h0;
					armed_r    <= 1'b0;
					pulse_r    <= 1'b0;
				end else begin
					pulse_r <= 1'b0;
					if (!rst_sync2_r || !line_en[g] || !vector_valid) begin
						// Lines are ignored in reset, in other roles and with no vector.
						idle_cnt_r <= 2'h0;
						act_cnt_r  <= 2'h0;
						armed_r    <= 1'b0;
					end else if (!sync2_r[g]) begin
						// Arm on the last inactive cycle of the minimum, not one later.
						act_cnt_r <= 2'h0;
						if (idle_cnt_r != 2'(IPFE_MIN_INACTIVE - 1))
							idle_cnt_r <= idle_cnt_r + 2'h1;
						else
							armed_r <= 1'b1;
					end else if (armed_r) begin
						idle_cnt_r <= 2'h0;
						if (act_cnt_r == 2'(IPFE_MIN_ACTIVE - 1)) begin
							pulse_r <= 1'b1;
							armed_r <= 1'b0;
							act_cnt_r <= 2'h0;
						end else
							act_cnt_r <= act_cnt_r + 2'h1;
					end else
						idle_cnt_r <= 2'h0;
				end
			end
			assign irq_pulse[g] = pulse_r;
		end
	endgenerate

	// External-controller request is a plain level from the third pin.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ext_controller_request <= 1'b0;
		else
			ext_controller_request <= ext_mode & rst_sync2_r & sync2_r[IPFE_IRQ_TWO];
	end

	// Acknowledge latch: loads only between transactions, holds while one runs.
	logic ack_latch_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ack_latch_r <= IPFE_ACK_RESET;
		else if (!ack_active)
			ack_latch_r <= ack_drive;
	end
	assign pins.irq_three_or_ack_out_o  = ack_latch_r;
	assign pins.irq_three_or_ack_out_oe = ack_mode & rst_sync2_r;

endmodule : ipfe_device

// [hdl/ipfe_source.sv]
// Source end: turns user request pulses direct_irq_zero legal pin waveforms and drives straps.
// Assumes the device samples at the same clk; pins are active low.
`timescale 1ns/1ns
module ipfe_source
	import ipfe_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Pins toward the device.
	ipfe_if.source           pins,
	// User side.
	input  wire logic [3:0]  req,
	input  wire logic [3:0]  strap_n,
	output logic [3:0]       busy
);

	// Strap levels go out on the pins while reset is low, so the device sees them.
	logic in_run_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			in_run_r <= 1'b0;
		else
			in_run_r <= 1'b1;
	end

	// Per line: hold inactive for HOLD cycles, then active for HOLD + 2 cycles, both above the minimum, then release.
	localparam int unsigned HOLD = IPFE_MIN_INACTIVE + 1;
	logic [3:0] level_r;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_line
			logic [2:0] cnt_r;
			logic       act_r;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cnt_r <= 3'h0;
					act_r <= 1'b0;
				end else if (cnt_r != 3'h0) begin
					cnt_r <= cnt_r - 3'h1;
					if (cnt_r == 3'h1 && !act_r) begin
						act_r <= 1'b1;
						cnt_r <= 3'(HOLD + 2);
					end else if (cnt_r == 3'h1)
						act_r <= 1'b0;
				end else if (req[g] && in_run_r)
					cnt_r <= 3'(HOLD);
			end
			assign level_r[g] = act_r;
			assign busy[g]    = (cnt_r != 3'h0) | act_r;
		end
	endgenerate

	// Pins: straps during reset, request levels afterward; fourth pin high at reset.
	assign pins.irq_n_low = in_run_r ? ~level_r[2:0] : strap_n[2:0];
	assign pins.lock_n    = in_run_r ? 1'b1 : strap_n[3];
	assign pins.irq_three_src_o  = in_run_r ? ~level_r[3] : 1'b1;
	assign pins.irq_three_src_oe = ~pins.irq_three_or_ack_out_oe;

endmodule : ipfe_source

// [tb/ipfe_props.sv]
// Checker for the pins between the two ends and the device results.
// Assumes one clock and that the bench instantiates it beside the interface.
`timescale 1ns/1ns
module ipfe_props
	import ipfe_pkg::*;
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       arst_n,
	// Pins and settings.
	input wire logic [2:0] irq_n_low,
	input wire logic       irq_three_or_ack_out_o,
	input wire logic       irq_three_or_ack_out_oe,
	input wire logic       vector_valid,
	input wire logic       ext_mode,
	input wire logic       ack_mode,
	input wire logic       ack_active,
	// Device results.
	input wire logic [3:0] irq_pulse,
	input wire logic       ext_controller_request,
	input wire ipfe_init_e init_mode,
	input wire logic       on_circuit_emulation_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Ack mode must hand the fourth pin to the device within two edges.
	property p_ack_oe; $rose(ack_mode) |-> ##[0:2] irq_three_or_ack_out_oe; endproperty
	a_ack_oe: assert property (p_ack_oe) else $error("ack pin not driven");
	// The latch must not move while a transaction runs.
	property p_ack_hold;
		ack_active && $past(ack_active) |-> $stable(irq_three_or_ack_out_o);
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack latch moved");
	// Without a vector no line may raise a pulse.
	property p_no_vec; !vector_valid [*4] |-> irq_pulse == 4'h0; endproperty
	a_no_vec: assert property (p_no_vec) else $error("pulse without vector");
	// A pulse on line zero lasts one cycle.
	property p_one; irq_pulse[0] |=> !irq_pulse[0]; endproperty
	a_one: assert property (p_one) else $error("pulse too long");
	// A pulse on line one must follow a pin that was really active.
	property p_cause; $rose(irq_pulse[1]) |-> !$past(irq_n_low[1], 3); endproperty
	a_cause: assert property (p_cause) else $error("pulse without pin");
	// External request follows the third pin with a three-cycle lag.
	property p_ext;
		ext_mode && $past(ext_mode, 3) && vector_valid && $past(vector_valid, 3)
			|-> ext_controller_request == !$past(irq_n_low[2], 3);
	endproperty
	a_ext: assert property (p_ext) else $error("external request wrong");
	// Direct mode never shows an external request.
	property p_direct; !ext_mode [*4] |-> !ext_controller_request; endproperty
	a_direct: assert property (p_direct) else $error("request in direct mode");
	// Emulation flag agrees with the captured choice.
	property p_emul;
		on_circuit_emulation_mode == (init_mode == IPFE_INIT_EMULATION);
	endproperty
	a_emul: assert property (p_emul) else $error("emulation flag wrong");
endmodule : ipfe_props

// [tb/interrupt_pin_front_end_tb.sv]
// Bench joining the device end to the source end through the pin interface.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ns
module interrupt_pin_front_end_tb
	import ipfe_pkg::*;
;
	// Stimulus and results; inputs change on the falling edge.
	logic       clk = 0, arst_n = 0, vector_valid = 0, ext_mode = 0;
	logic       ack_mode = 0, ack_drive = 1, ack_active = 0;
	logic [3:0] req = 4'h0, strap_n = 4'hF, irq_pulse, busy, n;
	logic       ext_controller_request, on_circuit_emulation_mode, e;
	ipfe_init_e init_mode;
	int         errors = 0, check_count = 0;
	logic [3:0] straps [4] = '{4'hF, 4'hC, 4'hE, 4'h7};
	ipfe_init_e modes  [4] = '{IPFE_INIT_SELF_TEST, IPFE_INIT_SKIP_TEST,
		IPFE_INIT_RESERVED, IPFE_INIT_EMULATION};
	ipfe_if bus ();
	always #10 clk = ~clk;
	// The fourth pin has a pull-up, so it idles high when nobody drives it.
	assign bus.irq_three_i = bus.irq_three_or_ack_out_oe ? bus.irq_three_or_ack_out_o :
		bus.irq_three_src_oe ? bus.irq_three_src_o : 1'b1;
	ipfe_device u_ipfe_device (.clk, .arst_n, .pins(bus.device), .vector_valid, .ext_mode,
		.ack_mode, .ack_drive, .ack_active, .irq_pulse, .ext_controller_request,
		.init_mode, .on_circuit_emulation_mode);
	ipfe_source u_ipfe_source (.clk, .arst_n, .pins(bus.source), .req, .strap_n, .busy);
	ipfe_props u_ipfe_props (.clk, .arst_n, .irq_n_low(bus.irq_n_low),
		.irq_three_or_ack_out_o(bus.irq_three_or_ack_out_o),
		.irq_three_or_ack_out_oe(bus.irq_three_or_ack_out_oe), .vector_valid, .ext_mode,
		.ack_mode, .ack_active, .irq_pulse, .ext_controller_request, .init_mode,
		.on_circuit_emulation_mode);
	// Compares one value and counts the result.
	task check(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then stops.
	task conclude;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// Resets with the given straps, held past release since they are sampled late.
	task do_reset(input logic [3:0] s);
		arst_n = 0;
		strap_n = s;
		// One clk spans two double-rate cycles, so half the minimum, rounded up.
		repeat ((IPFE_RESET_MIN_DOUBLE_RATE_CLOCK + 1) / 2) @(negedge clk);
		arst_n = 1;
		repeat (6) @(negedge clk);
		strap_n = 4'hF;
	endtask : do_reset
	// One request pulse; counts device pulses and notes any external request.
	task fire(input int i);
		n = 4'h0;
		e = 0;
		req[i] = 1;
		@(negedge clk);
		req[i] = 0;
		repeat (30) begin
			@(negedge clk);
			n = n + {3'b000, irq_pulse[i]};
			e = e | ext_controller_request;
		end
		check(busy, 4'h0);
	endtask : fire
	// The bounded watchdog cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end
	initial begin
		@(negedge clk);
		for (int k = 0; k < 4; k++) begin
			do_reset(straps[k]);
			check({2'b00, init_mode}, {2'b00, modes[k]});
			check({3'b000, on_circuit_emulation_mode}, {3'b000, k == 3});
		end
		$display("test straps done");
		do_reset(4'hF);
		fire(0);
		check(n, 4'h0);
		vector_valid = 1;
		for (int i = 0; i < 4; i++) begin
			fire(i);
			check(n, 4'h1);
		end
		$display("test direct done");
		ext_mode = 1;
		fire(2);
		check({3'b000, e}, 4'h1);
		check(n, 4'h0);
		ext_mode = 0;
		$display("test external done");
		ack_mode = 1;
		ack_drive = 0;
		repeat (3) @(negedge clk);
		check({2'b00, bus.irq_three_or_ack_out_oe, bus.irq_three_i}, 4'h2);
		ack_active = 1;
		ack_drive = 1;
		repeat (3) @(negedge clk);
		check({2'b00, bus.irq_three_or_ack_out_oe, bus.irq_three_i}, 4'h2);
		ack_active = 0;
		repeat (3) @(negedge clk);
		check({2'b00, bus.irq_three_or_ack_out_oe, bus.irq_three_i}, 4'h3);
		$display("test ack done");
		conclude();
	end
endmodule : interrupt_pin_front_end_tb
